//--- counter_top.sv
`timescale 1ns/10ps
module counter_top
  import counter_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic async_clear_n,
  output logic [3:0] count_value,
  output logic terminal_flag
);
  counter_if cif();

  // address phase qualifiers
  logic addr_phase;
  logic rd_start;
  logic wr_start;
  // data phase tracking
  logic wr_pending;
  logic next_wr_pending;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic wr_ctrl;
  // control register
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  // read path
  logic [31:0] status_word;
  logic [31:0] next_hrdata;
  // pin copies of the core state
  logic [3:0] next_count_value;
  logic next_terminal_flag;

  // no wait states: every transfer completes in its first data phase
  assign hreadyout = 1'b1;
  assign hresp = hresp_okay;

  // idle and busy carry no transfer; htrans[1] alone marks nonseq or seq
  assign addr_phase = hsel && hready && htrans[1];
  assign rd_start = addr_phase && !hwrite;
  assign wr_start = addr_phase && hwrite;
  assign wr_ctrl = wr_pending && (wr_addr == ctrl_offset);

  assign cif.load_n = ctrl[ctrl_load_n_bit];
  assign cif.count_enable_parallel = ctrl[ctrl_cep_bit];
  assign cif.count_enable_trickle = ctrl[ctrl_cet_bit];
  assign cif.decade = ctrl[ctrl_decade_bit];
  assign cif.load_value = ctrl[ctrl_value_lsb +: 4];

  counter_core u_core
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_clear_n(async_clear_n),
    .cif(cif)
  );

  // remember which write owns the coming data phase
  always_comb
  begin
    next_wr_pending = wr_start;
    next_wr_addr = wr_addr;
    if (addr_phase)
    begin
      next_wr_addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pending <= next_wr_pending;
      wr_addr <= next_wr_addr;
    end
  end

  // a write lands at the end of its data phase; counting keeps running meanwhile
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      // only the low byte holds fields, so the rest reads back as zero
      next_ctrl = {24'h00_0000, hwdata[7:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= ctrl_reset;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // status shows the core state as it stands at the address phase edge
  assign status_word = {27'h000_0000, cif.terminal_flag, cif.count_value};

  always_comb
  begin
    next_hrdata = hrdata;
    if (rd_start)
    begin
      unique case (haddr[7:0])
        ctrl_offset: next_hrdata = ctrl;
        status_offset: next_hrdata = status_word;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      hrdata <= next_hrdata;
    end
  end

  always_comb
  begin
    next_count_value = cif.count_value;
    next_terminal_flag = cif.terminal_flag;
  end

  // the pins are one edge behind the core, so the clear must reach them directly
  // as well; otherwise a stale count would show until the next edge
  always_ff @(posedge hclk or negedge hresetn or negedge async_clear_n)
  begin
    if (!hresetn || !async_clear_n)
    begin
      count_value <= count_zero;
      terminal_flag <= 1'b0;
    end
    else
    begin
      count_value <= next_count_value;
      terminal_flag <= next_terminal_flag;
    end
  end
endmodule

//--- counter_pkg.sv
package counter_pkg;
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam int ctrl_load_n_bit = 0;
  localparam int ctrl_cep_bit = 1;
  localparam int ctrl_cet_bit = 2;
  localparam int ctrl_decade_bit = 3;
  localparam int ctrl_value_lsb = 4;
  localparam int status_flag_bit = 4;
  localparam logic [31:0] ctrl_reset = 32'h0000_0001;
  localparam logic [3:0] decade_terminal = 4'h9;
  localparam logic [3:0] binary_terminal = 4'hf;
  localparam logic [3:0] count_zero = 4'h0;
  localparam logic [3:0] count_step = 4'h1;
  localparam logic [1:0] htrans_idle = 2'h0;
  localparam logic hresp_okay = 1'b0;
endpackage

//--- counter_if.sv
`timescale 1ns/10ps
interface counter_if;
  logic load_n;
  logic count_enable_parallel;
  logic count_enable_trickle;
  logic decade;
  logic [3:0] load_value;
  logic [3:0] count_value;
  logic terminal_flag;
  modport core
  (
    input load_n,
    input count_enable_parallel,
    input count_enable_trickle,
    input decade,
    input load_value,
    output count_value,
    output terminal_flag
  );
  modport ctrl
  (
    output load_n,
    output count_enable_parallel,
    output count_enable_trickle,
    output decade,
    output load_value,
    input count_value,
    input terminal_flag
  );
endinterface

//--- counter_core.sv
`timescale 1ns/10ps
module counter_core
  import counter_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_clear_n,
  counter_if.core cif
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] terminal;
  logic at_terminal;

  assign terminal = cif.decade ? decade_terminal : binary_terminal;
  assign at_terminal = (count == terminal);
  // combinational here, but the top registers the terminal_flag pin, so a cascade on it sees the trickle enable one clock late
  assign cif.terminal_flag = cif.count_enable_trickle & at_terminal;
  assign cif.count_value = count;

  always_comb
  begin
    next_count = count;
    if (!cif.load_n)
    begin
      next_count = cif.load_value;
    end
    else if (cif.count_enable_parallel && cif.count_enable_trickle)
    begin
      if (at_terminal)
      begin
        next_count = count_zero;
      end
      else
      begin
        next_count = 4'(count + count_step);
      end
    end
  end

  // cif controls reach the state only through next_count at the edge; reset and the clear act at once
  always_ff @(posedge hclk or negedge hresetn or negedge async_clear_n)
  begin
    if (!hresetn || !async_clear_n)
    begin
      count <= count_zero;
    end
    else
    begin
      count <= next_count;
    end
  end
endmodule

//--- clear_src.sv
`timescale 1ns/10ps
module clear_src (
  input wire logic clr,
  output logic async_clear_n
);
  // no clock here, so the clear lands mid-cycle as a real clear would
  assign async_clear_n = !clr;
endmodule

//--- counter_top_sva.sv
`timescale 1ns/10ps
module counter_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic async_clear_n,
  input wire logic [3:0] count_value,
  input wire logic terminal_flag
);
  logic wr_start;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a load written here shows on the pins four edges later
  assign wr_start = hsel && hready && htrans[1] && hwrite;
  AST_CLEAR: assert property (!async_clear_n |=> count_value == 4'h0)
    else $error("count not cleared");
  AST_FLAG_STATE: assert property (terminal_flag |-> count_value inside {4'h9, 4'hf})
    else $error("flag off terminal");
  AST_CLEAR_FLAG: assert property (!async_clear_n |=> !terminal_flag)
    else $error("flag during clear");
  AST_CLEAR_NOW: assert property (!async_clear_n |-> count_value == 4'h0 && !terminal_flag)
    else $error("count not cleared at once");
  AST_CLEAR_RELEASE: assert property ($rose(async_clear_n) |-> count_value == 4'h0)
    else $error("count moved during clear");
  AST_COUNT_STEP: assert property (count_value != $past(count_value)
    && count_value != 4'($past(count_value) + 4'h1) && count_value != 4'h0
    |-> $past(wr_start, 4))
    else $error("count jumped with no load behind it");
endmodule
bind counter_top counter_chk chk (.*);

//--- counter_top_test.sv
`timescale 1ns/10ps
module counter_top_test;
  import counter_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic clr = 1'b0;
  logic [1:0] htrans = htrans_idle;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, terminal_flag, async_clear_n;
  logic [3:0] count_value;
  logic [7:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  initial forever #50 hclk = !hclk;
  clear_src far (.clr(clr), .async_clear_n(async_clear_n));
  counter_top dut
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .async_clear_n(async_clear_n),
    .count_value(count_value),
    .terminal_flag(terminal_flag)
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic ack();
    int i;
    for (i = 0; i < 9; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    n_mismatch++;
    $display("mismatch %0t no ready", $time);
    results();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    ack();
    htrans <= htrans_idle;
    hwdata <= {24'h0, d};
    ack();
    rd = hrdata[7:0];
    check({7'h0, hresp}, {7'h0, hresp_okay});
  endtask
  task automatic load_hold();
    xfer(1'b1, ctrl_offset, 8'h7e);
    xfer(1'b1, ctrl_offset, 8'h7b);
    repeat (3) @(posedge hclk);
    xfer(1'b0, status_offset, 8'h0);
    check(rd, 8'h07);
    xfer(1'b0, 8'h40, 8'h0);
    check(rd, 8'h00);
  endtask
  task automatic wrap(input logic d, input logic [3:0] t);
    int i;
    xfer(1'b1, ctrl_offset, {t, d, 3'b010});
    // one edge for the load to reach the core before status is sampled
    @(posedge hclk);
    xfer(1'b0, status_offset, 8'h0);
    check(rd, {4'h0, t});
    check({7'h0, terminal_flag}, 8'h00);
    xfer(1'b1, ctrl_offset, {t, d, 3'b101});
    xfer(1'b0, status_offset, 8'h0);
    check(rd, {3'h0, 1'b1, t});
    check({7'h0, terminal_flag}, 8'h01);
    xfer(1'b1, ctrl_offset, {t, d, 3'b111});
    // a short bound so a decade count running past nine cannot reach zero in time
    for (i = 0; i < 4 && count_value !== count_zero; i++)
      @(posedge hclk);
    if (count_value !== count_zero)
    begin
      n_mismatch++;
      $display("mismatch %0t no wrap to zero", $time);
      results();
    end
    @(posedge hclk);
    check({4'h0, count_value}, 8'h01);
  endtask
  task automatic clear_run();
    clr <= 1'b1;
    #10;
    check({4'h0, count_value}, 8'h00);
    check({7'h0, terminal_flag}, 8'h00);
    repeat (2) @(posedge hclk);
    check({4'h0, count_value}, 8'h00);
    clr <= 1'b0;
    repeat (3) @(posedge hclk);
    check({4'h0, count_value}, 8'h01);
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, ctrl_offset, 8'h0);
    check(rd, ctrl_reset[7:0]);
    load_hold();
    wrap(1'b1, decade_terminal);
    wrap(1'b0, binary_terminal);
    clear_run();
    results();
  end
endmodule
